/* File: src/prc_reset_irq.sv */
// reset sequencing, protection flags and interrupt output with an axi4-lite register slave
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module prc_reset_irq #(
    parameter int unsigned SC_CYCLES = prc_pkg::SC_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // axi4-lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device pins and analog monitors, asynchronous
    input wire logic chip_reset_in_n,
    input wire logic analog_supply_uv,
    input wire logic [3:0] ilim_raw,
    input wire logic [3:0] pg_raw,
    input wire logic [3:0] fb_low_raw,
    input wire logic twarn_raw,
    input wire logic tsd_raw,
    // measurement engine, same clock
    input wire logic load_meas_done,
    // outputs
    output logic [3:0] core_en,
    output logic irq_out_n
);
    localparam logic [prc_pkg::DB_W-1:0] DB_LAST = prc_pkg::DB_W'(prc_pkg::DEBOUNCE_CYCLES - 1);
    localparam logic [prc_pkg::SC_W-1:0] SC_LAST = prc_pkg::SC_W'(SC_CYCLES - 1);
    localparam logic [prc_pkg::POR_W-1:0] POR_LAST = prc_pkg::POR_W'(prc_pkg::POR_CYCLES - 1);

    // input synchronisers: three stages, a change counts once stages two and three agree
    logic [15:0] s1_reg, s2_reg, s3_reg, sync_reg;
    wire [15:0] async_in = {analog_supply_uv, chip_reset_in_n, tsd_raw, twarn_raw, fb_low_raw, pg_raw, ilim_raw};
    wire [15:0] agree = ~(s2_reg ^ s3_reg);
    wire [15:0] sync_next = (agree & s3_reg) | (~agree & sync_reg);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= prc_pkg::SYNC_RESET;
            s2_reg <= prc_pkg::SYNC_RESET;
            s3_reg <= prc_pkg::SYNC_RESET;
            sync_reg <= prc_pkg::SYNC_RESET;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            sync_reg <= sync_next;
        end
    end
    // a glitch seen by one stage only never reaches the logic
    wire uv_s = sync_reg[15];
    wire pin_n_s = sync_reg[14];
    wire [3:0] fb_low_s = sync_reg[11:8];

    // 20 us debounce on current limit, power-good, thermal warning and shutdown
    wire [9:0] filt_reg;
    logic [9:0] filt_d_reg;
    wire [9:0] db_in = {sync_reg[13:12], sync_reg[7:0]};
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_db
            // both edges need the full window, so chatter never flags
            logic [prc_pkg::DB_W-1:0] cnt_reg;
            logic lvl_reg;
            assign filt_reg[gi] = lvl_reg;
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    cnt_reg <= '0;
                    lvl_reg <= 1'b0;
                end else if (db_in[gi] == lvl_reg) begin
                    cnt_reg <= '0;
                end else if (cnt_reg == DB_LAST) begin
                    cnt_reg <= '0;
                    lvl_reg <= db_in[gi];
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    endgenerate

    // a one-cycle delay turns filtered levels into edge pulses
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_d_reg <= '0;
        end else begin
            filt_d_reg <= filt_reg;
        end
    end
    wire [3:0] ilim_f = filt_reg[3:0];
    wire [3:0] pg_f = filt_reg[7:4];
    wire twarn_f = filt_reg[8];
    wire tsd_f = filt_reg[9];
    // only a rising edge raises a flag, so a held level is reported once
    wire [9:0] rise = filt_reg & ~filt_d_reg;

    // power state: held off, loading defaults, running
    prc_pkg::prc_state_e state_reg, state_next;
    logic [prc_pkg::POR_W-1:0] por_cnt_reg;
    logic soft_rst;
    wire hold = !pin_n_s || uv_s;
    wire por_done = por_cnt_reg == POR_LAST;
    wire go_run = (state_reg == prc_pkg::ST_LOAD) && !hold && por_done;

    // a soft reset reruns the load phase without dropping to off
    always_comb begin
        case (state_reg)
            prc_pkg::ST_OFF: state_next = hold ? prc_pkg::ST_OFF : prc_pkg::ST_LOAD;
            prc_pkg::ST_LOAD: state_next = hold ? prc_pkg::ST_OFF : (por_done ? prc_pkg::ST_RUN : prc_pkg::ST_LOAD);
            prc_pkg::ST_RUN: state_next = hold ? prc_pkg::ST_OFF : (soft_rst ? prc_pkg::ST_LOAD : prc_pkg::ST_RUN);
            default: state_next = prc_pkg::ST_OFF;
        endcase
    end

    // the load counter runs only in the load state, so each entry starts at zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= prc_pkg::ST_OFF;
            por_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            por_cnt_reg <= (state_reg == prc_pkg::ST_LOAD && !por_done) ? por_cnt_reg + 1'b1 : '0;
        end
    end
    // registers sit at defaults whenever the device is not running
    wire reg_clear = state_reg != prc_pkg::ST_RUN;

    // axi4-lite slave; reset only by reset_n so a soft reset never cuts a transfer
    logic aw_free_reg, w_free_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg;
    logic [7:0] awaddr_reg;
    logic [3:0] wstrb_reg;
    wire aw_take = s_axi_awvalid && aw_free_reg;
    wire w_take = s_axi_wvalid && w_free_reg;
    wire wr_fire = !aw_free_reg && !w_free_reg && !bvalid_reg;
    wire ar_take = s_axi_arvalid && arready_reg;

    // strobes mask the data so a partial write leaves other lanes alone
    wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wire [31:0] wd = wdata_reg & wmask;
    wire wr_hit_ctrl = wr_fire && awaddr_reg == prc_pkg::ADDR_CTRL;
    wire wr_hit_topf = wr_fire && awaddr_reg == prc_pkg::ADDR_TOP_FLAGS;
    wire wr_hit_topm = wr_fire && awaddr_reg == prc_pkg::ADDR_TOP_MASK;
    wire wr_hit_coref = wr_fire && awaddr_reg == prc_pkg::ADDR_CORE_FLAGS;
    wire wr_hit_corem = wr_fire && awaddr_reg == prc_pkg::ADDR_CORE_MASK;
    wire wr_hit_stat = wr_fire && awaddr_reg == prc_pkg::ADDR_STATUS;
    wire wr_mapped = wr_hit_ctrl || wr_hit_topf || wr_hit_topm || wr_hit_coref || wr_hit_corem || wr_hit_stat;

    wire [7:0] araddr8 = s_axi_araddr[7:0];
    wire ar_upper_ok = s_axi_araddr[31:8] == 24'h000000;
    // a write above the map is squashed to an unmapped offset when taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_free_reg <= 1'b1;
            w_free_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= prc_pkg::RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_free_reg <= 1'b0;
                awaddr_reg <= (s_axi_awaddr[31:8] == 24'h000000) ? s_axi_awaddr[7:0] : 8'hff;
            end
            if (w_take) begin
                w_free_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            // the answer waits until both halves are in, in either order
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                aw_free_reg <= 1'b1;
                w_free_reg <= 1'b1;
            end
        end
    end

    // soft reset is a pulse, the bit itself is never stored
    assign soft_rst = wr_hit_ctrl && wd[prc_pkg::CTRL_SOFT_RESET_BIT];

    // control and mask registers
    logic [3:0] en_req_reg, top_mask_reg;
    logic [7:0] core_mask_reg;
    // writes land only while running; otherwise defaults are held
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_req_reg <= prc_pkg::CTRL_EN_DEFAULT;
            top_mask_reg <= prc_pkg::TOP_MASK_DEFAULT;
            core_mask_reg <= prc_pkg::CORE_MASK_DEFAULT;
        end else if (reg_clear) begin
            en_req_reg <= prc_pkg::CTRL_EN_DEFAULT;
            top_mask_reg <= prc_pkg::TOP_MASK_DEFAULT;
            core_mask_reg <= prc_pkg::CORE_MASK_DEFAULT;
        end else begin
            if (wr_hit_ctrl && wstrb_reg[0]) begin
                en_req_reg <= wd[prc_pkg::CTRL_EN_LSB +: 4];
            end
            // the shutdown mask bit stays low: that flag cannot be hidden
            if (wr_hit_topm && wstrb_reg[0]) begin
                top_mask_reg <= wd[3:0] & 4'hb;
            end
            if (wr_hit_corem && wstrb_reg[0]) begin
                core_mask_reg <= wd[7:0];
            end
        end
    end

    // short-circuit / overload timers, one per core
    wire [3:0] sc_hit;
    logic [3:0] core_en_reg;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sc
            logic [prc_pkg::SC_W-1:0] cnt_reg;
            assign sc_hit[gi] = core_en_reg[gi] && fb_low_s[gi] && cnt_reg == SC_LAST;
            // the count restarts once the output recovers or the core is off
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    cnt_reg <= '0;
                end else if (!core_en_reg[gi] || !fb_low_s[gi] || sc_hit[gi]) begin
                    cnt_reg <= '0;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    endgenerate

    // sticky flags; an event in the clearing cycle wins, live conditions block the clear
    prc_pkg::prc_top_flags_s top_reg, top_next, top_d;
    prc_pkg::prc_core_flags_s core_reg, core_next, core_d;
    wire [3:0] top_clr = wr_hit_topf ? wd[3:0] : 4'h0;
    wire [11:0] core_clr = wr_hit_coref ? wd[11:0] : 12'h000;
    // power-good clears are never blocked: no live fault stands behind them
    always_comb begin
        top_next.rst = top_reg.rst && !top_clr[0];
        top_next.twarn = rise[8] || (top_reg.twarn && !(top_clr[1] && !twarn_f));
        top_next.tsd = rise[9] || (top_reg.tsd && !(top_clr[2] && !tsd_f));
        top_next.load = load_meas_done || (top_reg.load && !top_clr[3]);
        core_next.ilim = rise[3:0] | (core_reg.ilim & ~(core_clr[3:0] & ~ilim_f));
        core_next.pg = rise[7:4] | (core_reg.pg & ~core_clr[7:4]);
        core_next.sc = sc_hit | (core_reg.sc & ~core_clr[11:8]);
    end
    // the start-up that follows any reset or undervoltage leaves the reset-occurred flag set
    assign top_d = reg_clear ? prc_pkg::prc_top_flags_s'({3'b000, go_run}) : top_next;
    assign core_d = reg_clear ? prc_pkg::prc_core_flags_s'(12'h000) : core_next;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            top_reg <= '0;
            core_reg <= '0;
        end else begin
            top_reg <= top_d;
            core_reg <= core_d;
        end
    end

    // core enables: a cleared short-circuit flag retries the core while requested
    wire tsd_block = tsd_f || top_reg.tsd;
    wire [3:0] core_on_next = reg_clear ? 4'h0 : (en_req_reg & ~core_reg.sc & ~{4{tsd_block}});
    wire [3:0] core_sum = core_reg.ilim | core_reg.pg | core_reg.sc;

    // thermal shutdown and short circuit have no mask bit
    wire pend_top = |(top_reg & ~top_mask_reg);
    wire pend_core = |(core_reg.ilim & ~core_mask_reg[3:0]) || |(core_reg.pg & ~core_mask_reg[7:4]) || |core_reg.sc;
    wire irq_next_n = !(pend_top || pend_core);
    // registered so the pin never glitches while flags change
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            core_en_reg <= 4'h0;
            irq_out_n <= 1'b1;
        end else begin
            core_en_reg <= core_on_next;
            irq_out_n <= irq_next_n;
        end
    end

    // read path
    wire [31:0] rd_ctrl = {24'h000000, en_req_reg, 4'h0};
    wire [31:0] rd_topf = {24'h000000, core_sum, top_reg};
    wire [31:0] rd_topm = {28'h0000000, top_mask_reg};
    wire [31:0] rd_coref = {20'h00000, core_reg};
    wire [31:0] rd_corem = {24'h000000, core_mask_reg};
    wire [31:0] rd_stat = {16'h0000, core_en_reg, 2'b00, tsd_f, twarn_f, pg_f, ilim_f};

    wire hit_ctrl = araddr8 == prc_pkg::ADDR_CTRL;
    wire hit_topf = araddr8 == prc_pkg::ADDR_TOP_FLAGS;
    wire hit_topm = araddr8 == prc_pkg::ADDR_TOP_MASK;
    wire hit_coref = araddr8 == prc_pkg::ADDR_CORE_FLAGS;
    wire hit_corem = araddr8 == prc_pkg::ADDR_CORE_MASK;
    wire hit_stat = araddr8 == prc_pkg::ADDR_STATUS;

    wire rd_mapped = ar_upper_ok && (hit_ctrl || hit_topf || hit_topm || hit_coref || hit_corem || hit_stat);
    wire [31:0] rd_mux = !ar_upper_ok ? 32'h00000000 :
                         hit_ctrl ? rd_ctrl :
                         hit_topf ? rd_topf :
                         hit_topm ? rd_topm :
                         hit_coref ? rd_coref :
                         hit_corem ? rd_corem :
                         hit_stat ? rd_stat : 32'h00000000;

    // read data is caught at the address handshake and held until taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= prc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_mapped ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // bus outputs come straight from their flops
    assign s_axi_awready = aw_free_reg;
    assign s_axi_wready = w_free_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign core_en = core_en_reg;
endmodule
`default_nettype wire

/* File: common/prc_pkg.sv */
// constants, types and register map of the reset and interrupt controller
package prc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TOP_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_TOP_MASK = 8'h08;
    localparam logic [7:0] ADDR_CORE_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_CORE_MASK = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // field positions
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_EN_LSB = 4;
    localparam int TOP_CORE_SUM_LSB = 4;
    localparam int STAT_TWARN_BIT = 8;
    localparam int STAT_TSD_BIT = 9;
    localparam int STAT_CORE_ON_LSB = 12;
    // reset values
    localparam logic [3:0] CTRL_EN_DEFAULT = 4'h0;
    localparam logic [3:0] TOP_MASK_DEFAULT = 4'h0;
    localparam logic [7:0] CORE_MASK_DEFAULT = 8'h00;
    localparam logic [15:0] SYNC_RESET = 16'h8000;
    // timing
    localparam int CLK_MHZ = 125;
    localparam int DEBOUNCE_US = 20;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
    localparam int SC_MS = 1;
    localparam int SC_CYCLES_DEFAULT = SC_MS * 1000 * CLK_MHZ;
    localparam int POR_CYCLES = 16;
    localparam int DB_W = 12;
    localparam int SC_W = 17;
    localparam int POR_W = 5;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_LOAD = 3'b010,
        ST_RUN = 3'b100
    } prc_state_e;

    typedef struct packed {
        logic [3:0] sc;
        logic [3:0] pg;
        logic [3:0] ilim;
    } prc_core_flags_s;

    typedef struct packed {
        logic load;
        logic tsd;
        logic twarn;
        logic rst;
    } prc_top_flags_s;
endpackage

/* File: test/prc_conv_model.sv */
// converter stage model answering the core enables with monitor levels
`timescale 1ns/1ps
`default_nettype none
module prc_conv_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // enables from the controller, faults from the bench
    input wire logic [3:0] core_en,
    input wire logic [3:0] short_req,
    input wire logic [3:0] ilim_req,
    // analog monitor levels
    output logic [3:0] pg_raw,
    output logic [3:0] fb_low_raw,
    output logic [3:0] ilim_raw
);
    // one cycle of soft start: far quicker than a real ramp, still inside the short timer
    logic [3:0] up_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) up_reg <= 4'h0;
        else up_reg <= core_en;
    end
    // a disabled or shorted output sits below the low threshold
    assign fb_low_raw = ~up_reg | short_req;
    assign pg_raw = up_reg & ~short_req;
    assign ilim_raw = ilim_req & core_en;
endmodule
`default_nettype wire

/* File: test/prc_reset_irq_monitor.sv */
// assertion checker of the reset and interrupt controller
`timescale 1ns/1ps
`default_nettype none
module prc_reset_irq_monitor #(
    parameter int unsigned SC_CYCLES = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus handshakes
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // pins and outputs
    input wire logic chip_reset_in_n,
    input wire logic analog_supply_uv,
    input wire logic [3:0] fb_low_raw,
    input wire logic [3:0] core_en,
    input wire logic irq_out_n
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // pin and supply good for 8 cycles, so the synchronisers have settled
    logic [3:0] good_cnt;
    int unsigned sc_cnt;
    wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            good_cnt <= 4'h0;
            sc_cnt <= 0;
        end else begin
            good_cnt <= (!chip_reset_in_n || analog_supply_uv) ? 4'h0 : good_cnt + {3'h0, good_cnt != 4'h8};
            sc_cnt <= (core_en[0] && fb_low_raw[0]) ? sc_cnt + 1 : 0;
        end
    end
    property p_b_lat; wr_take |-> ##2 s_axi_bvalid; endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_ready_back; s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready; endproperty
    a_ready_back: assert property (p_ready_back) else $error("write channel stuck");
    property p_pin_off; !chip_reset_in_n [*7] |-> core_en == 4'h0; endproperty
    a_pin_off: assert property (p_pin_off) else $error("cores on with pin low");
    property p_uv_off; analog_supply_uv [*7] |-> core_en == 4'h0; endproperty
    a_uv_off: assert property (p_uv_off) else $error("cores on in undervoltage");
    property p_soft_off; wr_take && s_axi_awaddr == 32'h0 && s_axi_wdata[0] |-> ##[1:5] core_en == 4'h0; endproperty
    a_soft_off: assert property (p_soft_off) else $error("cores on after soft reset");
    property p_sc_limit; sc_cnt <= SC_CYCLES + 10; endproperty
    a_sc_limit: assert property (p_sc_limit) else $error("short not caught");
    property p_irq_hold;
        !irq_out_n && good_cnt == 4'h8 && !s_axi_bvalid && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)
        |=> !irq_out_n;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt released without a write");
endmodule
bind prc_reset_irq prc_reset_irq_monitor #(.SC_CYCLES(SC_CYCLES)) u_mon (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .chip_reset_in_n, .analog_supply_uv, .fb_low_raw, .core_en, .irq_out_n
);
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench of the reset and interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {logic [31:0] a, d, r; logic [1:0] s;} prc_row_s;
    localparam logic [31:0] A_CTRL = {24'h0, prc_pkg::ADDR_CTRL};
    localparam logic [31:0] A_TOP = {24'h0, prc_pkg::ADDR_TOP_FLAGS};
    localparam logic [31:0] A_TM = {24'h0, prc_pkg::ADDR_TOP_MASK};
    localparam logic [31:0] A_CF = {24'h0, prc_pkg::ADDR_CORE_FLAGS};
    localparam logic [31:0] A_CM = {24'h0, prc_pkg::ADDR_CORE_MASK};
    localparam logic [31:0] A_ST = {24'h0, prc_pkg::ADDR_STATUS};
    localparam logic [1:0] OK = prc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = prc_pkg::RESP_SLVERR;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0, rv;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic pin_n = 1'b1, uv = 1'b0, twarn = 1'b0, tsd = 1'b0, meas = 1'b0;
    logic [3:0] ilim_req = 4'h0, short_req = 4'h0;
    logic [1:0] rs;
    wire logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq_n;
    wire logic [1:0] b_resp, r_resp;
    wire logic [31:0] r_d;
    wire logic [3:0] pg, fbl, ilim, core_en;
    int n_fail = 0;
    int checked = 0;
    prc_row_s rows [6] = '{'{A_TM, 32'hf, 32'hb, OK}, '{A_CM, 32'hffff, 32'hff, OK}, '{A_CM, 32'h0, 32'h0, OK},
        '{A_TM, 32'h0, 32'h0, OK}, '{32'h18, 32'h1, 32'h0, ERR}, '{32'h100, 32'h1, 32'h0, ERR}};
    always #4 clk = ~clk;
    prc_reset_irq #(.SC_CYCLES(20)) DUT (
        .clk(clk), .reset_n(reset_n), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .chip_reset_in_n(pin_n),
        .analog_supply_uv(uv), .ilim_raw(ilim), .pg_raw(pg), .fb_low_raw(fbl), .twarn_raw(twarn), .tsd_raw(tsd),
        .load_meas_done(meas), .core_en(core_en), .irq_out_n(irq_n));
    prc_conv_model u_conv (.clk(clk), .reset_n(reset_n), .core_en(core_en), .short_req(short_req),
        .ilim_req(ilim_req), .pg_raw(pg), .fb_low_raw(fbl), .ilim_raw(ilim));
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (!b_v);
        rs = b_resp;
        b_r <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_rdy) ar_v <= 1'b0;
        end while (!r_v);
        rv = r_d;
        rs = r_resp;
        r_r <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, e, rv);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // the run needs about 18700 cycles
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        test_done;
    end
    initial begin
        logic [31:0] fa;
        logic [31:0] fm;
        waitc(6);
        reset_n <= 1'b1;
        waitc(40);
        chk("irq por", 32'h0, irq_n);
        rchk("top por", A_TOP, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].a, rows[i].d);
            chk("bresp", rows[i].s, rs);
            rchk("rdata", rows[i].a, rows[i].r);
            chk("rresp", rows[i].s, rs);
        end
        $display("register table done");
        wr(A_TOP, 32'h1);
        waitc(2);
        chk("irq clr", 32'h1, irq_n);
        wr(A_TM, 32'h8);
        meas <= 1'b1;
        @(posedge clk);
        meas <= 1'b0;
        waitc(3);
        chk("irq masked", 32'h1, irq_n);
        rchk("load flag", A_TOP, 32'h8);
        wr(A_TM, 32'h0);
        waitc(2);
        chk("irq unmask", 32'h0, irq_n);
        wr(A_TOP, 32'h8);
        waitc(2);
        chk("irq load", 32'h1, irq_n);
        wr(A_CTRL, 32'h10);
        waitc(2600);
        chk("core on", 32'h1, core_en);
        rchk("pg flag", A_CF, 32'h10);
        rchk("summary", A_TOP, 32'h10);
        chk("irq pg", 32'h0, irq_n);
        wr(A_CF, 32'h10);
        $display("event tests done");
        // thermal warning, then current limit: both refuse a clear while active
        for (int k = 0; k < 2; k++) begin
            fa = k ? A_CF : A_TOP;
            fm = k ? 32'h1 : 32'h2;
            ilim_req <= {3'h0, k == 1};
            twarn <= (k == 0);
            waitc(2600);
            rchk("flag", fa, fm);
            rchk("status", A_ST, k ? 32'h1011 : 32'h1110);
            chk("irq set", 32'h0, irq_n);
            wr(fa, fm);
            rchk("clr refused", fa, fm);
            ilim_req <= 4'h0;
            twarn <= 1'b0;
            waitc(2600);
            wr(fa, fm);
            rchk("clr ok", fa, 32'h0);
            chk("irq free", 32'h1, irq_n);
        end
        $display("sticky tests done");
        short_req <= 4'h1;
        waitc(40);
        chk("sc off", 32'h0, core_en);
        rchk("sc flag", A_CF, 32'h100);
        short_req <= 4'h0;
        wr(A_CF, 32'h100);
        waitc(2);
        chk("retry", 32'h1, core_en);
        tsd <= 1'b1;
        waitc(2600);
        chk("tsd off", 32'h0, core_en);
        wr(A_CTRL, 32'h30);
        waitc(4);
        chk("tsd hold", 32'h0, core_en);
        tsd <= 1'b0;
        waitc(2600);
        chk("tsd flag hold", 32'h0, core_en);
        wr(A_TOP, 32'h4);
        waitc(3);
        chk("tsd retry", 32'h3, core_en);
        wr(A_CTRL, 32'h31);
        waitc(2);
        chk("soft off", 32'h0, core_en);
        waitc(30);
        rchk("soft ctrl", A_CTRL, 32'h0);
        rchk("soft top", A_TOP, 32'h1);
        chk("soft bus", OK, rs);
        $display("protection tests done");
        // pin low first, then supply undervoltage
        for (int s = 0; s < 2; s++) begin
            wr(A_TOP, 32'h1);
            wr(A_CTRL, 32'h10);
            waitc(2);
            pin_n <= (s != 0);
            uv <= (s == 1);
            waitc(8);
            chk("dev off", 32'h0, core_en);
            rd(A_CTRL);
            chk("bus alive", OK, rs);
            pin_n <= 1'b1;
            uv <= 1'b0;
            waitc(40);
            rchk("ctrl dflt", A_CTRL, 32'h0);
            rchk("rst flag", A_TOP, 32'h1);
        end
        $display("device reset tests done");
        test_done;
    end
endmodule
`default_nettype wire
